// ===== rtl/pmr_pkg.sv
// Constants and types for the power mode and reset controller
// What this block does
// - Writing the stop-select bit enters Stop mode when that write completes.
// - Stop halts internal oscillator, CPU, peripherals; external one runs on.
// - Only a reset ends Stop; then normal reset sequence, fetch from 0x0000.
// - Writing the suspend bit halts CPU and fast oscillator; state is kept.
// - In Suspend only port match, and Timer 3 on external clock, run.
// - Suspend ends on port match, timer 2 wrap, comparator low, sense, reset.
// - Non-reset wake resumes at the next instruction; interrupts follow.
// - A reset ending Suspend runs the normal reset sequence from 0x0000.
// - Suspend is entered even with wakes pending; earlier edge events never wake.
// - Port match wake is level sensitive, so a standing match wakes.
// - Bit 7 powers the supply monitor; it resets only when also selected.
// - Supply monitor enable reads 1 after power-on; other resets keep it.
// - Read-only bit 6 shows supply monitor output, 1 when above threshold.
// - Supply monitor control bits 5:0 unused; writes to them are ignored.
// - Pin driven low resets; the pin-reset flag bit 0 sets on exit.
// - Clock-loss detector is a retriggered one-shot; stuck clock resets.
// - Bit 2 reads 1 after clock-loss reset; writing it enables the detector.
// - A clock-loss reset never drives or changes the external reset pin.
package pmr_pkg;
   // Register indices, byte address is four times the index
   localparam logic [7:0] PWR_CTRL_IDX   = 8'h87;
   localparam logic [7:0] RST_SRC_IDX    = 8'hEF;
   localparam logic [7:0] SUP_MON_IDX    = 8'hFF;
   localparam logic [7:0] OSC_CTRL_IDX   = 8'hC0;
   localparam logic [7:0] CLK_SEL_IDX    = 8'hC1;
   localparam logic [7:0] WAKE_CTRL_IDX  = 8'hC2;
   // Field positions
   localparam int STOP_BIT      = 1;
   localparam int PIN_FLAG_BIT  = 0;
   localparam int SUP_SEL_BIT   = 1;
   localparam int CLK_LOSS_BIT  = 2;
   localparam int SUP_EN_BIT    = 7;
   localparam int SUP_STAT_BIT  = 6;
   localparam int SUSP_BIT      = 5;
   localparam int CMP_WAKE_BIT  = 0;
   localparam int T3_EXT_BIT    = 1;
   localparam int DIV_LSB       = 0;
   localparam int DIV_W         = 3;
   // Synchroniser lanes
   localparam int IN_W          = 7;
   localparam int IN_MON_CLK    = 0;
   localparam int IN_CS_GT      = 1;
   localparam int IN_CMP_LOW    = 2;
   localparam int IN_T2_OVF     = 3;
   localparam int IN_PORT_MATCH = 4;
   localparam int IN_SUP_ABOVE  = 5;
   localparam int IN_EXT_RST_N  = 6;
   localparam logic [IN_W-1:0] SYNC_RST_VAL = 7'h60;
   // Reset values
   localparam logic            SUP_EN_RST   = 1'b1;
   localparam logic            CLK_LOSS_RST = 1'b1;
   localparam logic [DIV_W-1:0] DIV_RST     = 3'h0;
   localparam logic [15:0]     RESET_VECTOR = 16'h0000;
   // Timing
   localparam int CLK_MHZ         = 200;
   localparam int CLK_LOSS_US     = 100;
   localparam int CLK_LOSS_CYC    = CLK_LOSS_US * CLK_MHZ;
   localparam int CNT_W           = 16;
   localparam logic [4:0] RST_HOLD_CYC = 5'h10;
   typedef enum logic [1:0] {
      PMR_RUN,
      PMR_STOP,
      PMR_SUSP
   } pmr_mode_t;
endpackage

// ===== rtl/pmr_power_reset_ctrl.sv
// Power mode, reset source and clock-loss detector controller
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/10ps
module pmr_power_reset_ctrl #(
   parameter int CLK_LOSS_TIMEOUT_CYC = pmr_pkg::CLK_LOSS_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [9:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic        ext_reset_n_i,
   input  wire logic        supply_above_i,
   input  wire logic        port_match_i,
   input  wire logic        timer2_ovf_i,
   input  wire logic        comparator_low_i,
   input  wire logic        sense_gt_i,
   input  wire logic        sys_clk_mon_i,
   output logic             sys_reset_o,
   output logic [15:0]      boot_addr_o,
   output logic             int_osc_halt_o,
   output logic             cpu_halt_o,
   output logic             periph_halt_o,
   output logic             port_match_run_o,
   output logic             timer3_run_o,
   output logic             wake_o,
   output logic             supply_mon_on_o,
   output logic [2:0]       clock_divide_field_o
);
   logic [pmr_pkg::IN_W-1:0]  sync1_r;
   logic [pmr_pkg::IN_W-1:0]  sync2_r;
   logic [pmr_pkg::IN_W-1:0]  prev_r;
   logic                      ack_r;
   logic [7:0]                rdat_r;
   logic                      sys_rst_r;
   logic [4:0]                hold_r;
   logic                      cause_pin_r;
   logic                      cause_loss_r;
   logic                      pin_flag_r;
   logic                      loss_flag_r;
   logic                      loss_en_r;
   logic                      sup_sel_r;
   logic                      sup_en_r;
   logic [pmr_pkg::CNT_W-1:0] loss_cnt_r;
   logic                      loss_fire_r;
   logic [pmr_pkg::DIV_W-1:0] div_r;
   logic                      cmp_wake_en_r;
   logic                      t3_ext_r;
   logic                      wake_r;
   logic [15:0]               boot_r;
   pmr_pkg::pmr_mode_t        mode_r;
   pmr_pkg::pmr_mode_t        mode_nxt;
   logic                      hit;
   logic                      wr_fire;
   logic                      rd_load;
   logic [7:0]                idx;
   logic [7:0]                wdat;
   logic [7:0]                rdat_nxt;
   logic                      src_pin;
   logic                      src_sup;
   logic                      any_src;
   logic                      rst_exit;
   logic                      pin_low_s;
   logic                      above_s;
   logic                      port_match_s;
   logic                      mon_edge;
   logic                      ev_rise;
   logic                      wake_hit;
   logic                      low_power;

   function automatic logic is_wr(input logic [7:0] a,
                                  input logic [7:0] r,
                                  input logic       f);
      return f && (a == r);
   endfunction

   // Two-stage synchronisers for all pin and foreign inputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_r <= pmr_pkg::SYNC_RST_VAL;
         sync2_r <= pmr_pkg::SYNC_RST_VAL;
         prev_r  <= pmr_pkg::SYNC_RST_VAL;
      end else begin
         sync1_r <= {ext_reset_n_i, supply_above_i, port_match_i,
                     timer2_ovf_i, comparator_low_i, sense_gt_i,
                     sys_clk_mon_i};
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   assign pin_low_s    = !sync2_r[pmr_pkg::IN_EXT_RST_N];
   assign above_s      = sync2_r[pmr_pkg::IN_SUP_ABOVE];
   assign port_match_s = sync2_r[pmr_pkg::IN_PORT_MATCH];
   assign mon_edge     = sync2_r[pmr_pkg::IN_MON_CLK]
                         ^ prev_r[pmr_pkg::IN_MON_CLK];

   // Wishbone classic slave, one wait state
   assign hit     = cyc_i && stb_i;
   assign idx     = adr_i[9:2];
   assign wdat    = dat_i[7:0];
   assign wr_fire = hit && we_i && ack_r && sel_i[0];
   assign rd_load = hit && !ack_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= hit && !ack_r;
      end
   end

   always_comb begin
      rdat_nxt = 8'h00;
      case (idx)
         pmr_pkg::PWR_CTRL_IDX: begin
            rdat_nxt[pmr_pkg::STOP_BIT] = (mode_r == pmr_pkg::PMR_STOP);
         end
         pmr_pkg::RST_SRC_IDX: begin
            rdat_nxt[pmr_pkg::PIN_FLAG_BIT] = pin_flag_r;
            rdat_nxt[pmr_pkg::SUP_SEL_BIT]  = sup_sel_r;
            rdat_nxt[pmr_pkg::CLK_LOSS_BIT] = loss_flag_r;
         end
         pmr_pkg::SUP_MON_IDX: begin
            rdat_nxt[pmr_pkg::SUP_EN_BIT]   = sup_en_r;
            rdat_nxt[pmr_pkg::SUP_STAT_BIT] = above_s;
         end
         pmr_pkg::OSC_CTRL_IDX: begin
            rdat_nxt[pmr_pkg::SUSP_BIT] = (mode_r == pmr_pkg::PMR_SUSP);
         end
         pmr_pkg::CLK_SEL_IDX: begin
            rdat_nxt[pmr_pkg::DIV_LSB +: pmr_pkg::DIV_W] = div_r;
         end
         pmr_pkg::WAKE_CTRL_IDX: begin
            rdat_nxt[pmr_pkg::CMP_WAKE_BIT] = cmp_wake_en_r;
            rdat_nxt[pmr_pkg::T3_EXT_BIT]   = t3_ext_r;
         end
         default: begin
            rdat_nxt = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_r <= 8'h00;
      end else if (rd_load) begin
         rdat_r <= rdat_nxt;
      end
   end

   // Software settings; supply enable survives every non-power-on reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sup_en_r <= pmr_pkg::SUP_EN_RST;
      end else if (is_wr(idx, pmr_pkg::SUP_MON_IDX, wr_fire)) begin
         sup_en_r <= wdat[pmr_pkg::SUP_EN_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loss_en_r <= pmr_pkg::CLK_LOSS_RST;
         sup_sel_r <= 1'b0;
      end else if (is_wr(idx, pmr_pkg::RST_SRC_IDX, wr_fire)) begin
         loss_en_r <= wdat[pmr_pkg::CLK_LOSS_BIT];
         sup_sel_r <= wdat[pmr_pkg::SUP_SEL_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || sys_rst_r) begin
         div_r         <= pmr_pkg::DIV_RST;
         cmp_wake_en_r <= 1'b0;
         t3_ext_r      <= 1'b0;
      end else begin
         if (is_wr(idx, pmr_pkg::CLK_SEL_IDX, wr_fire)) begin
            div_r <= wdat[pmr_pkg::DIV_LSB +: pmr_pkg::DIV_W];
         end
         if (is_wr(idx, pmr_pkg::WAKE_CTRL_IDX, wr_fire)) begin
            cmp_wake_en_r <= wdat[pmr_pkg::CMP_WAKE_BIT];
            t3_ext_r      <= wdat[pmr_pkg::T3_EXT_BIT];
         end
      end
   end

   localparam logic [pmr_pkg::CNT_W-1:0] CNT_MAX =
      pmr_pkg::CNT_W'(CLK_LOSS_TIMEOUT_CYC);
   // Clock-loss one-shot, retriggered by each edge of the system clock
   always_ff @(posedge clk_i) begin
      if (rst_i || sys_rst_r || mon_edge) begin
         loss_cnt_r <= '0;
      end else if (loss_cnt_r != CNT_MAX) begin
         loss_cnt_r <= loss_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loss_fire_r <= 1'b0;
      end else begin
         loss_fire_r <= loss_en_r && (loss_cnt_r == CNT_MAX);
      end
   end
   // Reset sequencer; the pin is only an input here
   assign src_pin  = pin_low_s;
   assign src_sup  = sup_en_r && sup_sel_r && !above_s;
   assign any_src  = src_pin || src_sup || loss_fire_r;
   assign rst_exit = sys_rst_r && !any_src && (hold_r == 5'h00);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_r    <= pmr_pkg::RST_HOLD_CYC;
         sys_rst_r <= 1'b1;
      end else begin
         if (any_src) begin
            hold_r <= pmr_pkg::RST_HOLD_CYC;
         end else if (hold_r != 5'h00) begin
            hold_r <= hold_r - 5'h01;
         end
         sys_rst_r <= any_src || (hold_r != 5'h00);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || rst_exit) begin
         cause_pin_r  <= 1'b0;
         cause_loss_r <= 1'b0;
      end else begin
         cause_pin_r  <= cause_pin_r || src_pin;
         cause_loss_r <= cause_loss_r || loss_fire_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_flag_r  <= 1'b0;
         loss_flag_r <= 1'b0;
      end else if (rst_exit) begin
         pin_flag_r  <= cause_pin_r;
         loss_flag_r <= cause_loss_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         boot_r <= pmr_pkg::RESET_VECTOR;
      end else begin
         boot_r <= pmr_pkg::RESET_VECTOR;
      end
   end

   // Wake detection runs on clk_i, not on the halted fast oscillator
   assign ev_rise = (sync2_r[pmr_pkg::IN_T2_OVF]
                     && !prev_r[pmr_pkg::IN_T2_OVF])
                  || (cmp_wake_en_r && sync2_r[pmr_pkg::IN_CMP_LOW]
                     && !prev_r[pmr_pkg::IN_CMP_LOW])
                  || (sync2_r[pmr_pkg::IN_CS_GT]
                     && !prev_r[pmr_pkg::IN_CS_GT]);
   assign wake_hit = (mode_r == pmr_pkg::PMR_SUSP)
                     && (port_match_s || ev_rise);
   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         pmr_pkg::PMR_RUN: begin
            if (is_wr(idx, pmr_pkg::PWR_CTRL_IDX, wr_fire)
                && wdat[pmr_pkg::STOP_BIT]) begin
               mode_nxt = pmr_pkg::PMR_STOP;
            end else if (is_wr(idx, pmr_pkg::OSC_CTRL_IDX, wr_fire)
                         && wdat[pmr_pkg::SUSP_BIT]) begin
               mode_nxt = pmr_pkg::PMR_SUSP;
            end
         end
         pmr_pkg::PMR_STOP: begin
            mode_nxt = pmr_pkg::PMR_STOP;
         end
         pmr_pkg::PMR_SUSP: begin
            if (wake_hit) begin
               mode_nxt = pmr_pkg::PMR_RUN;
            end
         end
         default: begin
            mode_nxt = pmr_pkg::PMR_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || sys_rst_r) begin
         mode_r <= pmr_pkg::PMR_RUN;
         wake_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         wake_r <= wake_hit;
      end
   end

   // Halt controls; the external oscillator has no control here
   assign low_power = (mode_r != pmr_pkg::PMR_RUN);
   assign dat_o                = {24'h000000, rdat_r};
   assign ack_o                = ack_r;
   assign sys_reset_o          = sys_rst_r;
   assign boot_addr_o          = boot_r;
   assign int_osc_halt_o       = low_power;
   assign cpu_halt_o           = low_power;
   assign periph_halt_o        = low_power;
   assign port_match_run_o     = (mode_r != pmr_pkg::PMR_STOP);
   assign timer3_run_o         = (mode_r == pmr_pkg::PMR_RUN)
                                 || ((mode_r == pmr_pkg::PMR_SUSP)
                                     && t3_ext_r);
   assign wake_o               = wake_r;
   assign supply_mon_on_o      = sup_en_r;
   assign clock_divide_field_o = div_r;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_stop_req;
      is_wr(idx, pmr_pkg::PWR_CTRL_IDX, wr_fire)
      && wdat[pmr_pkg::STOP_BIT] && (mode_r == pmr_pkg::PMR_RUN)
      && !sys_rst_r;
   endsequence
   sequence s_susp_req;
      is_wr(idx, pmr_pkg::OSC_CTRL_IDX, wr_fire)
      && wdat[pmr_pkg::SUSP_BIT] && !wdat[pmr_pkg::STOP_BIT]
      && (mode_r == pmr_pkg::PMR_RUN) && !sys_rst_r;
   endsequence
   property p_stop_entry;
      s_stop_req |=> (mode_r == pmr_pkg::PMR_STOP) && cpu_halt_o;
   endproperty
   a_stop_entry: assert property (p_stop_entry)
      else $error("stop not entered after write");
   property p_stop_halts;
      (mode_r == pmr_pkg::PMR_STOP) |-> int_osc_halt_o && cpu_halt_o
         && periph_halt_o && !timer3_run_o;
   endproperty
   a_stop_halts: assert property (p_stop_halts)
      else $error("stop left logic running");
   property p_stop_hold;
      (mode_r == pmr_pkg::PMR_STOP) && !sys_rst_r
         |=> (mode_r == pmr_pkg::PMR_STOP) || $past(sys_rst_r);
   endproperty
   a_stop_hold: assert property (p_stop_hold)
      else $error("stop ended without reset");
   property p_susp_entry;
      s_susp_req |=> (mode_r == pmr_pkg::PMR_SUSP) && int_osc_halt_o;
   endproperty
   a_susp_entry: assert property (p_susp_entry)
      else $error("suspend not entered");
   property p_susp_wake;
      wake_hit && !sys_rst_r |=> (mode_r == pmr_pkg::PMR_RUN) && wake_o;
   endproperty
   a_susp_wake: assert property (p_susp_wake)
      else $error("wake event ignored");
   property p_no_stale_wake;
      (mode_r == pmr_pkg::PMR_SUSP) && !wake_hit && !sys_rst_r
         |=> (mode_r == pmr_pkg::PMR_SUSP);
   endproperty
   a_no_stale_wake: assert property (p_no_stale_wake)
      else $error("suspend left without wake event");
   property p_level_match;
      (mode_r == pmr_pkg::PMR_SUSP) && port_match_s && !sys_rst_r
         |=> (mode_r == pmr_pkg::PMR_RUN);
   endproperty
   a_level_match: assert property (p_level_match)
      else $error("standing port match did not wake");
   property p_reset_ends_mode;
      sys_rst_r |=> (mode_r == pmr_pkg::PMR_RUN) && !wake_o;
   endproperty
   a_reset_ends_mode: assert property (p_reset_ends_mode)
      else $error("reset did not end low power mode");
   property p_sup_reset;
      sup_en_r && sup_sel_r && !above_s |=> sys_rst_r;
   endproperty
   a_sup_reset: assert property (p_sup_reset)
      else $error("selected supply monitor did not reset");
   property p_sup_en_kept;
      $rose(sys_rst_r) |-> $stable(sup_en_r) [*2];
   endproperty
   a_sup_en_kept: assert property (p_sup_en_kept)
      else $error("supply enable lost in reset");
   property p_pin_flag;
      $fell(sys_rst_r) && $past(cause_pin_r) |-> pin_flag_r;
   endproperty
   a_pin_flag: assert property (p_pin_flag)
      else $error("pin reset flag not set on exit");
   property p_loss_reset;
      loss_en_r && (loss_cnt_r == CNT_MAX) && !sys_rst_r
         |-> ##2 sys_rst_r;
   endproperty
   a_loss_reset: assert property (p_loss_reset)
      else $error("clock loss did not reset");
   property p_loss_flag;
      $fell(sys_rst_r) |-> (loss_flag_r == $past(cause_loss_r));
   endproperty
   a_loss_flag: assert property (p_loss_flag)
      else $error("clock loss flag wrong after reset");
endmodule // pmr_power_reset_ctrl

// ===== dv/pmr_far_side.sv
// Far side model: external reset circuit and monitored system clock
`timescale 1ns/10ps
module pmr_far_side (
   input  wire logic clk_i,
   input  wire logic osc_halt_i,
   input  wire logic pin_req_i,
   output logic      ext_reset_n_o,
   output logic      sys_clk_mon_o
);
   logic [1:0] div_r = 2'h0;
   logic       mon_r = 1'b0;

   // Monitored clock runs at an eighth of the rate and stops with the oscillator
   always_ff @(posedge clk_i) begin
      if (!osc_halt_i) begin
         div_r <= div_r + 2'h1;
         if (div_r == 2'h3) begin
            mon_r <= ~mon_r;
         end
      end
   end

   assign sys_clk_mon_o = mon_r;
   // Pin has a pull-up, so it reads high whenever the request is released
   assign ext_reset_n_o = ~pin_req_i;
endmodule // pmr_far_side

// ===== dv/tb_top.sv
// Self-checking bench for the power mode and reset controller
`timescale 1ns/10ps
module tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [9:0]  adr_i = 10'h000;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd, seed = 32'd80486;
   logic        ack_o, ext_reset_n_i, sys_clk_mon_i, supply_above_i = 1'b1;
   logic [3:0]  ev = 4'h0;
   logic        pin_req = 1'b0;
   logic        sys_reset_o, int_osc_halt_o, cpu_halt_o, periph_halt_o;
   logic        port_match_run_o, timer3_run_o, wake_o, supply_mon_on_o;
   logic [15:0] boot_addr_o;
   logic [2:0]  clock_divide_field_o;
   int          bad_count = 0, comparisons = 0, cycles = 0;
   int          m_sup_en = 1, m_sel = 0, m_pin = 0, m_cl = 0, m_div = 0;
   int          m_wk = 0;
   bit          got;

   pmr_power_reset_ctrl #(.CLK_LOSS_TIMEOUT_CYC(50)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .ext_reset_n_i(ext_reset_n_i),
      .supply_above_i(supply_above_i), .port_match_i(ev[0]),
      .timer2_ovf_i(ev[1]), .comparator_low_i(ev[2]), .sense_gt_i(ev[3]),
      .sys_clk_mon_i(sys_clk_mon_i), .sys_reset_o(sys_reset_o),
      .boot_addr_o(boot_addr_o), .int_osc_halt_o(int_osc_halt_o),
      .cpu_halt_o(cpu_halt_o), .periph_halt_o(periph_halt_o),
      .port_match_run_o(port_match_run_o), .timer3_run_o(timer3_run_o),
      .wake_o(wake_o), .supply_mon_on_o(supply_mon_on_o),
      .clock_divide_field_o(clock_divide_field_o));

   pmr_far_side far (.clk_i(clk_i), .osc_halt_i(int_osc_halt_o),
      .pin_req_i(pin_req), .ext_reset_n_o(ext_reset_n_i),
      .sys_clk_mon_o(sys_clk_mon_i));

   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [31:0] exp_rd(input logic [7:0] idx);
      case (idx)
         8'hEF: return {29'h0, m_cl[0], m_sel[0], m_pin[0]};
         8'hFF: return {24'h0, m_sup_en[0], supply_above_i, 6'h00};
         8'hC1: return 32'(m_div);
         8'hC2: return 32'(m_wk);
         default: return 32'h0;
      endcase
   endfunction

   task automatic conclude();
      if (bad_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      sel_i <= 4'hF;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h000000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      check("ack", n, 2);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      wb(1'b1, idx, d);
      if (idx == 8'hFF) m_sup_en = d[7];
      if (idx == 8'hEF) m_sel = d[1];
      if (idx == 8'hC1) m_div = d[2:0];
      if (idx == 8'hC2) m_wk = d[1:0];
   endtask

   task automatic rdchk(input logic [7:0] idx);
      wb(1'b0, idx, 8'h00);
      check("read", rd, exp_rd(idx));
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // Wait up to n cycles for wake (w=0) or reset (w=1) to show val
   task automatic await(input int w, input logic val, input int n,
                        output bit hit);
      hit = 0;
      while (!hit && n > 0) begin
         @(posedge clk_i);
         n--;
         hit = ((w == 0) ? wake_o : sys_reset_o) === val;
      end
   endtask

   task automatic halts(input logic [4:0] exp);
      check("halts", {int_osc_halt_o, cpu_halt_o, periph_halt_o,
                      port_match_run_o, timer3_run_o}, {27'h0, exp});
   endtask

   task automatic reset_exit(input int pin);
      await(1, 1'b0, 80, got);
      check("release", got, 1);
      m_pin = pin;
      m_cl = !pin;
      m_div = 0;
      m_wk = 0;
      settle(1);
      halts(5'b00011);
      check("boot", boot_addr_o, 32'h0);
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 6000) begin
         bad_count++;
         conclude();
      end
   end

   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      await(1, 1'b0, 60, got);
      check("por", got, 1);
      #1 check("mon_on", supply_mon_on_o, 1);
      rdchk(8'hFF);
      wr(8'hEF, 8'h00);
      rdchk(8'hEF);
      wr(8'hFF, {2'b10, 6'(xs())});
      rdchk(8'hFF);
      supply_above_i <= 1'b0;
      await(1, 1'b1, 10, got);
      check("sup_rst", got, 0);
      rdchk(8'hFF);
      supply_above_i <= 1'b1;
      wr(8'h10, 8'(xs()));
      rdchk(8'h10);
      for (int i = 0; i < 3; i++) begin
         wr(8'hC1, 8'(xs()));
         settle(1);
         check("div", clock_divide_field_o, m_div);
      end
      wr(8'hC1, 8'h00);
      for (int k = 0; k < 4; k++) begin
         wr(8'hC2, {6'h0, k != 3, 1'b1});
         ev <= 4'h1 << k;
         settle(6);
         wr(8'hC0, 8'h20);
         if (k != 0) begin
            settle(1);
            halts({4'b1111, k != 3});
            await(0, 1'b1, 6, got);
            check("pending", got, 0);
            ev <= 4'h0;
            repeat (4) @(posedge clk_i);
            ev <= 4'h1 << k;
         end
         await(0, 1'b1, 12, got);
         check("wake", got, 1);
         ev <= 4'h0;
         settle(1);
         halts(5'b00011);
         rdchk(8'hC2);
      end
      wr(8'hFF, 8'h00);
      settle(1);
      check("mon_off", supply_mon_on_o, 0);
      wr(8'h87, 8'h02);
      ev <= 4'h2;
      settle(1);
      halts(5'b11100);
      await(0, 1'b1, 8, got);
      check("stop_wake", got, 0);
      ev <= 4'h0;
      pin_req <= 1'b1;
      await(1, 1'b1, 10, got);
      check("pin_rst", got, 1);
      pin_req <= 1'b0;
      reset_exit(1);
      check("mon_kept", supply_mon_on_o, 0);
      rdchk(8'hEF);
      rdchk(8'hC1);
      wr(8'hEF, 8'h04);
      await(1, 1'b1, 100, got);
      check("retrigger", got, 0);
      wr(8'h87, 8'h02);
      await(1, 1'b1, 120, got);
      check("loss_rst", got, 1);
      check("pin", ext_reset_n_i, 1);
      reset_exit(0);
      rdchk(8'hEF);
      wr(8'hC0, 8'h20);
      await(1, 1'b1, 120, got);
      check("susp_rst", got, 1);
      reset_exit(0);
      rdchk(8'hC0);
      wr(8'hFF, 8'h80);
      repeat (8) @(posedge clk_i);
      wr(8'hEF, 8'h06);
      supply_above_i <= 1'b0;
      await(1, 1'b1, 10, got);
      check("sup_sel_rst", got, 1);
      supply_above_i <= 1'b1;
      reset_exit(0);
      m_cl = 0;
      rdchk(8'hEF);
      conclude();
   end
endmodule // tb_top
